// ===== src/serial_vid_command_decoder.v
// Receive-only decoder for the two-wire serial voltage-identification link
// What this block does
// - Address accepted only when bits 6:4 equal 110; bit 3 is ignored.
// - Address bit 2 selects the second core rail, ignored in combined mode.
// - Address bit 1 selects first core rail, or unified rail when combined.
// - Address bit 0 selects the bridge rail.
// - Power-save flag 0: pulse-skipping after boot; on the first core or unified rail it also switches pin offset off.
// - Combined mode with power-save flag 0 runs the core single-phase.
// - Power-save flag 1: forced-PWM after boot; on the first core or unified rail it also applies pin offset again.
// - Combined mode with power-save flag 1 returns core to two-phase.
// - Data bits 6:0 are the voltage code for each selected rail.
// - Output above threshold at cycle start skips the on-pulse regardless.
// - Start: data falls while clock high, from any state.
// - Stop: data rises while clock high; every operation ends with it.
// - Acknowledge the address only on a match and outside programming mode.
// - Acknowledge by holding data low through the ninth clock high phase.
`timescale 1ns/1ns
`include "vid_link_map.vh"
module serial_vid_command_decoder (
	input wire sys_clk,
	input wire reset,
	input wire vid_link_clock,
	input wire vid_link_data,
	output reg vid_link_data_out,
	output reg vid_link_data_oe_n,
	input wire combine_detect_a,
	input wire combine_detect_b,
	input wire programming_mode,
	input wire boot_done,
	input wire offset_pin_enable,
	input wire above_threshold,
	output reg [6:0] second_core_code,
	output reg [6:0] first_core_code,
	output reg [6:0] bridge_code,
	output reg second_core_pwm,
	output reg first_core_pwm,
	output reg bridge_pwm,
	output reg offset_enable,
	output reg two_phase,
	output reg skip_pulse,
	output reg command_strobe
);
	localparam ST_IDLE = 5'b00001;
	localparam ST_ADDR = 5'b00010;
	localparam ST_ADDR_ACK = 5'b00100;
	localparam ST_DATA = 5'b01000;
	localparam ST_DATA_ACK = 5'b10000;

	wire clk_s;
	wire dat_s;
	reg clk_d;
	reg dat_d;
	reg [4:0] state;
	reg [3:0] bit_count;
	reg [7:0] shift;
	reg [2:0] selected;
	reg second_psave;
	reg first_psave;
	reg bridge_psave;
	reg combined;
	reg ack_drive;

	sync_two_ff u_sync_clk (
		.sys_clk(sys_clk),
		.reset(reset),
		.async_in(vid_link_clock),
		.sync_out(clk_s)
	);
	sync_two_ff u_sync_dat (
		.sys_clk(sys_clk),
		.reset(reset),
		.async_in(vid_link_data),
		.sync_out(dat_s)
	);

	// Link edges are found by sampling, so a half period must span several cycles
	wire clk_rise = clk_s & ~clk_d;
	wire clk_fall = ~clk_s & clk_d;
	wire start_cond = clk_s & clk_d & dat_d & ~dat_s;
	wire stop_cond = clk_s & clk_d & ~dat_d & dat_s;
	wire [7:0] rx_byte = {shift[6:0], dat_s};
	// The seven address bits sit above the direction bit in the first byte
	wire [6:0] rx_addr = rx_byte[7:1];
	wire combine_now = combine_detect_a | combine_detect_b;
	// Address match; bit 3 and the direction bit are don't-care
	wire addr_match = (rx_addr[`ADDR_PAT_HI:`ADDR_PAT_LO] == `ADDR_PATTERN);
	// In combined mode the second core select is dropped; bit 1 feeds the unified rail
	wire [2:0] sel_now = {rx_addr[`ADDR_SECOND_BIT] & ~combine_now,
		rx_addr[`ADDR_FIRST_BIT], rx_addr[`ADDR_BRIDGE_BIT]};

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			clk_d <= 1'b1;
			dat_d <= 1'b1;
			state <= ST_IDLE;
			bit_count <= 4'h0;
			shift <= 8'h00;
			selected <= 3'h0;
			ack_drive <= 1'b0;
			second_core_code <= `CODE_RESET;
			first_core_code <= `CODE_RESET;
			bridge_code <= `CODE_RESET;
			second_psave <= `PSAVE_RESET;
			first_psave <= `PSAVE_RESET;
			bridge_psave <= `PSAVE_RESET;
			combined <= 1'b0;
			command_strobe <= 1'b0;
		end else begin
			clk_d <= clk_s;
			dat_d <= dat_s;
			command_strobe <= 1'b0;
			combined <= combine_now;
			// Start and stop override any state, so a cut frame always recovers
			if (start_cond) begin
				state <= ST_ADDR;
				bit_count <= 4'h0;
				ack_drive <= 1'b0;
			end else if (stop_cond) begin
				state <= ST_IDLE;
				ack_drive <= 1'b0;
			end else begin
				case (state)
				ST_ADDR: begin
					if (clk_rise) begin
						shift <= rx_byte;
						bit_count <= bit_count + 4'h1;
						if (bit_count == `BIT_COUNT_LAST - 4'h1) begin
							if (addr_match && !programming_mode) begin
								selected <= sel_now;
								state <= ST_ADDR_ACK;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
				end
				ST_ADDR_ACK: begin
					// Drive low on the fall after bit 8, release after the ninth pulse
					if (clk_fall) begin
						if (ack_drive) begin
							ack_drive <= 1'b0;
							state <= ST_DATA;
							bit_count <= 4'h0;
						end else begin
							ack_drive <= 1'b1;
						end
					end
				end
				ST_DATA: begin
					if (clk_rise) begin
						shift <= rx_byte;
						bit_count <= bit_count + 4'h1;
						if (bit_count == `BIT_COUNT_LAST - 4'h1) begin
							state <= ST_DATA_ACK;
							command_strobe <= 1'b1;
							// Same byte goes to every selected rail
							if (selected[2]) begin
								second_core_code <= rx_byte[`CODE_WIDTH-1:0];
								second_psave <= rx_byte[`DATA_PSAVE_BIT];
							end
							if (selected[1]) begin
								first_core_code <= rx_byte[`CODE_WIDTH-1:0];
								first_psave <= rx_byte[`DATA_PSAVE_BIT];
							end
							if (selected[0]) begin
								bridge_code <= rx_byte[`CODE_WIDTH-1:0];
								bridge_psave <= rx_byte[`DATA_PSAVE_BIT];
							end
						end
					end
				end
				ST_DATA_ACK: begin
					if (clk_fall) begin
						if (ack_drive) begin
							ack_drive <= 1'b0;
							state <= ST_IDLE; // Further bytes wait for the next start
						end else begin
							ack_drive <= 1'b1;
						end
					end
				end
				ST_IDLE: begin
					ack_drive <= 1'b0;
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// Registered pin and mode outputs; PWM mode follows the flag only after boot
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			vid_link_data_out <= 1'b1;
			vid_link_data_oe_n <= 1'b1;
			second_core_pwm <= 1'b1;
			first_core_pwm <= 1'b1;
			bridge_pwm <= 1'b1;
			offset_enable <= 1'b0;
			two_phase <= 1'b1;
			skip_pulse <= 1'b0;
		end else begin
			vid_link_data_out <= 1'b0;
			vid_link_data_oe_n <= ~ack_drive;
			// Boot mode keeps forced-PWM until boot_done
			second_core_pwm <= ~boot_done | second_psave;
			first_core_pwm <= ~boot_done | first_psave;
			bridge_pwm <= ~boot_done | bridge_psave;
			// Offset and phase follow the first core flag, which also serves the unified rail
			offset_enable <= offset_pin_enable & first_psave;
			two_phase <= ~combined | first_psave;
			skip_pulse <= above_threshold;
		end
	end
endmodule // serial_vid_command_decoder

// ===== src/vid_link_map.vh
// Constants for the serial voltage-identification link decoder
`ifndef VID_LINK_MAP_VH
`define VID_LINK_MAP_VH
`define ADDR_PATTERN 3'b110
`define ADDR_PAT_HI 6
`define ADDR_PAT_LO 4
`define ADDR_SECOND_BIT 2
`define ADDR_FIRST_BIT 1
`define ADDR_BRIDGE_BIT 0
`define DATA_PSAVE_BIT 7
`define CODE_WIDTH 7
`define CODE_RESET 7'h00
`define PSAVE_RESET 1'b1
`define BIT_COUNT_LAST 4'h8
`endif

// ===== src/sync_two_ff.v
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module sync_two_ff (
	input wire sys_clk,
	input wire reset,
	input wire async_in,
	output reg sync_out
);
	reg stage_one;

	// Resets high because an idle bus line rests high
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			stage_one <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end
endmodule // sync_two_ff

// ===== tb/vid_master.sv
// Link master model: frames one address byte and one data byte
`timescale 1ns/1ns
module vid_master (
	input wire sys_clk,
	output reg link_clock,
	output reg link_data
);
	initial begin
		link_clock = 1'b1;
		link_data = 1'b1;
	end
	task w(input integer n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Last bit of each group is released high so the device can pull it low
	task bits(input [8:0] v);
		integer i;
		for (i = 8; i >= 0; i = i - 1) begin
			link_clock <= 1'b0;
			w(4);
			link_data <= v[i];
			w(4);
			link_clock <= 1'b1;
			w(8);
		end
	endtask
	task frame(input [6:0] a, input [7:0] d);
		begin
			link_data <= 1'b0;
			w(8);
			bits({a, 1'b1, 1'b1});
			bits({d, 1'b1});
			link_clock <= 1'b0;
			w(4);
			link_data <= 1'b0;
			w(4);
			link_clock <= 1'b1;
			w(8);
			link_data <= 1'b1;
			w(8);
		end
	endtask
endmodule // vid_master

// ===== tb/serial_vid_command_decoder_sva.sv
// Port assertions for the link decoder
`timescale 1ns/1ns
module serial_vid_command_decoder_sva (
	input wire sys_clk,
	input wire reset,
	input wire vid_link_data_out,
	input wire vid_link_data_oe_n,
	input wire combine_detect_a,
	input wire combine_detect_b,
	input wire programming_mode,
	input wire offset_pin_enable,
	input wire above_threshold,
	input wire [6:0] bridge_code,
	input wire offset_enable,
	input wire two_phase,
	input wire skip_pulse,
	input wire command_strobe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence ack_start;
		$fell(vid_link_data_oe_n);
	endsequence
	a_ack_holds_low: assert property (ack_start |=> !vid_link_data_oe_n [*8])
		else $error("ack released early");
	a_ack_ends_bounded: assert property (ack_start |-> ##[9:40] vid_link_data_oe_n)
		else $error("ack never released");
	a_ack_drives_low: assert property (!vid_link_data_oe_n |-> !vid_link_data_out)
		else $error("ack drives high");
	a_no_prog_ack: assert property (ack_start |-> !programming_mode)
		else $error("ack in programming mode");
	a_strobe_one_cycle: assert property (command_strobe |=> !command_strobe)
		else $error("strobe too long");
	a_code_needs_strobe: assert property ($changed(bridge_code) |->
		command_strobe || $past(command_strobe)) else $error("code changed without command");
	a_skip_follows_level: assert property ($changed(above_threshold) |=>
		skip_pulse == $past(above_threshold)) else $error("skip not following level");
	a_offset_pin_off: assert property (!offset_pin_enable |=> !offset_enable)
		else $error("offset without pin");
	a_split_two_phase: assert property (!(combine_detect_a || combine_detect_b) |-> ##2
		two_phase) else $error("single phase in split mode");
endmodule // serial_vid_command_decoder_sva
bind serial_vid_command_decoder serial_vid_command_decoder_sva serial_vid_command_decoder_sva_i (.*);

// ===== tb/serial_vid_command_decoder_tb_top.sv
// Testbench: frames commands and compares rail settings
`timescale 1ns/1ns
module serial_vid_command_decoder_tb_top;
	reg sys_clk = 1'b0, reset = 1'b1, prog = 1'b0, boot = 1'b0, opt = 1'b1, above = 1'b0;
	reg [1:0] comb = 2'b00;
	reg [6:0] e2 = 7'h00, e1 = 7'h00, eb = 7'h00;
	reg f2 = 1'b1, f1 = 1'b1, fb = 1'b1;
	wire [6:0] c2, c1, cb;
	wire p2, p1, pb, offs, twop, skip, stb, dout, oe_n, lclk, mdata;
	wire ldata = mdata & (oe_n | dout);
	integer err_count = 0, compares = 0, i;
	always #5 sys_clk = ~sys_clk;
	vid_master vid_master_i (.sys_clk(sys_clk), .link_clock(lclk), .link_data(mdata));
	serial_vid_command_decoder serial_vid_command_decoder_i (.sys_clk(sys_clk), .reset(reset),
		.vid_link_clock(lclk), .vid_link_data(ldata), .vid_link_data_out(dout),
		.vid_link_data_oe_n(oe_n), .combine_detect_a(comb[0]), .combine_detect_b(comb[1]),
		.programming_mode(prog), .boot_done(boot), .offset_pin_enable(opt),
		.above_threshold(above), .second_core_code(c2), .first_core_code(c1), .bridge_code(cb),
		.second_core_pwm(p2), .first_core_pwm(p1), .bridge_pwm(pb), .offset_enable(offs),
		.two_phase(twop), .skip_pulse(skip), .command_strobe(stb));
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task cmp;
		begin
			chk({c2, c1, cb, p2, p1, pb}, {e2, e1, eb, f2, f1, fb});
			chk({offs, twop}, {opt & f1, !(comb != 2'b00 && !f1)});
		end
	endtask
	task cmd(input [6:0] a, input [7:0] d, input ok);
		begin
			vid_master_i.frame(a, d);
			if (ok) begin
				if (a[2] && comb == 2'b00) {f2, e2} = d;
				if (a[1]) {f1, e1} = d;
				if (a[0]) {fb, eb} = d;
			end
			repeat (2) @(posedge sys_clk);
			cmp;
			$display("test a=%h d=%h done", a, d);
		end
	endtask
	task final_report;
		begin
			$display("compares=%0d err_count=%0d", compares, err_count);
			if (err_count == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		boot <= 1'b1;
		repeat (4) @(posedge sys_clk);
		cmp;
		for (i = 1; i < 16; i = i + 1)
			cmd({3'b110, i[3:0]}, {i[1], 3'h5, i[3:0]}, 1'b1);
		cmd(7'h77, 8'h2a, 1'b0);
		cmd(7'h27, 8'h2b, 1'b0);
		prog <= 1'b1;
		cmd(7'h67, 8'h11, 1'b0);
		prog <= 1'b0;
		comb <= 2'b01;
		cmd(7'h67, 8'h05, 1'b1);
		cmd(7'h63, 8'h85, 1'b1);
		comb <= 2'b10;
		cmd(7'h62, 8'h33, 1'b1);
		comb <= 2'b00;
		opt <= 1'b0;
		cmd(7'h62, 8'h99, 1'b1);
		cmd(7'h61, 8'h12, 1'b1);
		boot <= 1'b0;
		above <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(pb, 1);
		chk(skip, 1);
		final_report;
	end
	// Some twenty-three frames of about 3.2 us each; four times that is ample
	initial begin
		#300000;
		err_count = err_count + 1;
		final_report;
	end
endmodule // serial_vid_command_decoder_tb_top
